// ---- src/ssc_pkg.sv ----
// Register map, field layouts, reset values and clock codes of the synchronous serial port
package ssc_pkg;

   // Register byte offsets on the APB
   localparam logic [11:0] OFS_MODE_A   = 12'h000;
   localparam logic [11:0] OFS_MODE_B   = 12'h004;
   localparam logic [11:0] OFS_SHIFT    = 12'h008;
   localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

   // Field positions
   localparam int unsigned MA_LEN_LSB    = 0;
   localparam int unsigned MA_START_BIT  = 3;
   localparam int unsigned MA_LSB_BIT    = 4;
   localparam int unsigned MA_TXEDGE_BIT = 5;
   localparam int unsigned MA_RXEDGE_BIT = 6;
   localparam int unsigned MA_BUSY_BIT   = 7;
   localparam int unsigned MB_CKS_LSB    = 0;
   localparam int unsigned MB_INTCLK_BIT = 2;
   localparam int unsigned MB_RXEN_BIT   = 3;
   localparam int unsigned MB_TXEN_BIT   = 4;
   localparam int unsigned IRQ_DONE_BIT  = 0;

   // Reset values
   localparam logic [7:0] MODE_A_RST   = 8'h00;
   localparam logic [4:0] MODE_B_RST   = 5'h00;
   localparam logic [7:0] SHIFT_RST    = 8'h00;
   localparam logic [0:0] IRQ_RST      = 1'h0;

   // Clock source codes
   localparam logic [1:0] CKS_DIV2   = 2'h0;
   localparam logic [1:0] CKS_DIV8   = 2'h1;
   localparam logic [1:0] CKS_DIV64  = 2'h2;
   localparam logic [1:0] CKS_TIMER3 = 2'h3;

   // Base clock cycles per half period of the shift clock
   localparam logic [5:0] HALF_DIV2  = 6'h01;
   localparam logic [5:0] HALF_DIV8  = 6'h04;
   localparam logic [5:0] HALF_DIV64 = 6'h20;

   // Bit count field value 0 means a full byte
   localparam logic [3:0] FULL_LEN = 4'h8;

   typedef struct packed {
      logic       busy;
      logic       rx_edge_select;
      logic       tx_edge_select;
      logic       lsb_first;
      logic       start_en;
      logic [2:0] bit_len;
   } ssc_mode_a_t;

   typedef struct packed {
      logic       tx_en;
      logic       rx_en;
      logic       internal_clk;
      logic [1:0] clock_source_select;
   } ssc_mode_b_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_TAIL = 2'h3
   } ssc_state_t;

endpackage

// ---- src/ssc_sync_serial.sv ----
// Three-wire clock-synchronous serial port with APB registers
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// What this block does, and what software (RULE_08) and the peer (RULE_10) must do
// RULE_01: Software picks internal shift clock (master) or clock from the clock line (slave).
// RULE_02: Internal clock source field picks base clock /2, /8, /64 or timer 3 output.
// RULE_03: Only three lines: clock, separate serial out, separate serial in.
// RULE_04: Transmit-only use releases the serial input line for general use.
// RULE_05: Receive-only use releases the serial output line for general use.
// RULE_06: Busy flag goes to 1 as soon as a transfer is started.
// RULE_07: Busy flag clears in the same cycle the done interrupt is raised.
// RULE_08: Software uses edge pair 00 or 01 for simultaneous send and receive.
// RULE_09: In duplex use, input is sampled on the edge opposite the output edge.
// RULE_10: The peer launches its data on the edge opposite the device output edge.
// RULE_11: Transmit edge bit: 0 shifts out on falling edges, 1 on rising edges.
// RULE_12: Receive edge bit: 0 samples on opposite edge, 1 on the transmit edge.
// RULE_13: Master with start condition off: buffer write starts clock, done raises interrupt.
// RULE_14: Clock line is driven when internal clock selected, input otherwise.
// RULE_15: Unused serial input in transmit-only use reads as constant 1.
module ssc_sync_serial (
   input  wire logic        i_clk,          // Base system clock
   input  wire logic        i_reset,        // Synchronous reset, active high
   input  wire logic        i_psel,         // APB select
   input  wire logic        i_penable,      // APB enable
   input  wire logic        i_pwrite,       // APB write
   input  wire logic [11:0] i_paddr,        // APB byte address
   input  wire logic [31:0] i_pwdata,       // APB write data
   output logic      [31:0] o_prdata,       // APB read data
   output logic             o_pready,       // APB ready
   output logic             o_pslverr,      // APB error, unmapped address
   input  wire logic        i_timer3_tick,  // Timer 3 output pulse
   input  wire logic        i_sck_in,       // Clock line level
   output logic             o_sck_out,      // Clock line drive value
   output logic             o_sck_oe,       // Clock line drive enable
   input  wire logic        i_sdi_in,       // Serial input line level
   output logic             o_sdo_out,      // Serial output drive value
   output logic             o_sdo_oe,       // Serial output drive enable
   output logic             o_busy,         // Transfer in progress
   output logic             o_irq           // Level interrupt
);

   ssc_pkg::ssc_mode_a_t mode_a_q;
   ssc_pkg::ssc_mode_b_t mode_b_q;
   ssc_pkg::ssc_state_t  state_q;
   logic [7:0]           tx_sr_q;
   logic [7:0]           rx_sr_q;
   logic [3:0]           bit_cnt_q;
   logic [5:0]           div_q;
   logic                 sck_q;
   logic                 sdo_q;
   logic [0:0]           irq_stat_q;
   logic [0:0]           irq_mask_q;
   logic [31:0]          prdata_q;
   logic [1:0]           sck_sync_q;
   logic [1:0]           sdi_sync_q;
   logic                 sck_prev_q;

   logic       setup;
   logic       access;
   logic       wr;
   logic       addr_ok;
   logic [31:0] rd_data;
   logic       any_en;
   logic       idle_lvl;
   logic [5:0] half_cnt;
   logic       tick;
   logic       m_edge;
   logic       rise_e;
   logic       fall_e;
   logic       tx_edge;
   logic       rx_edge;
   logic       rx_on_rise;
   logic       slave_start;
   logic       master_start;
   logic       proc;
   logic       rx_bit;
   logic [3:0] len_n;
   logic       last_sample;
   logic       done;

   // APB decode
   assign setup   = i_psel & ~i_penable;
   assign access  = i_psel & i_penable;
   assign wr      = access & i_pwrite;
   assign addr_ok = (i_paddr == ssc_pkg::OFS_MODE_A) | (i_paddr == ssc_pkg::OFS_MODE_B) |
                    (i_paddr == ssc_pkg::OFS_SHIFT) | (i_paddr == ssc_pkg::OFS_IRQ_STAT) |
                    (i_paddr == ssc_pkg::OFS_IRQ_MASK);
   assign o_pready  = access;
   assign o_pslverr = access & ~addr_ok;
   assign o_prdata  = prdata_q;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (i_paddr)
         ssc_pkg::OFS_MODE_A: begin
            rd_data[7:0] = {(state_q != ssc_pkg::ST_IDLE), mode_a_q[6:0]};
         end
         ssc_pkg::OFS_MODE_B: begin
            rd_data[4:0] = mode_b_q;
         end
         ssc_pkg::OFS_SHIFT: begin
            rd_data[7:0] = rx_sr_q;
         end
         ssc_pkg::OFS_IRQ_STAT: begin
            rd_data[ssc_pkg::IRQ_DONE_BIT] = irq_stat_q[0];
         end
         ssc_pkg::OFS_IRQ_MASK: begin
            rd_data[ssc_pkg::IRQ_DONE_BIT] = irq_mask_q[0];
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup & ~i_pwrite) begin
         prdata_q <= rd_data;
      end
   end

   // Mode registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode_a_q <= ssc_pkg::MODE_A_RST;
         mode_b_q <= ssc_pkg::MODE_B_RST;
      end else if (wr) begin
         if (i_paddr == ssc_pkg::OFS_MODE_A) begin
            mode_a_q <= {1'b0, i_pwdata[6:0]};
         end
         if (i_paddr == ssc_pkg::OFS_MODE_B) begin
            mode_b_q <= i_pwdata[4:0]; // RULE_01
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sck_sync_q <= 2'h3;
         sdi_sync_q <= 2'h3;
         sck_prev_q <= 1'b1;
      end else begin
         sck_sync_q <= {sck_sync_q[0], i_sck_in};
         sdi_sync_q <= {sdi_sync_q[0], i_sdi_in};
         sck_prev_q <= sck_sync_q[1];
      end
   end

   assign any_en   = mode_b_q.tx_en | mode_b_q.rx_en;
   assign idle_lvl = ~mode_a_q.tx_edge_select;
   assign rx_bit   = mode_b_q.rx_en ? sdi_sync_q[1] : 1'b1; // RULE_04 RULE_15
   assign len_n    = (mode_a_q.bit_len == 3'h0) ? ssc_pkg::FULL_LEN : {1'b0, mode_a_q.bit_len};

   // Internal clock source selection
   always_comb begin
      case (mode_b_q.clock_source_select)
         ssc_pkg::CKS_DIV2:  half_cnt = ssc_pkg::HALF_DIV2; // RULE_02
         ssc_pkg::CKS_DIV8:  half_cnt = ssc_pkg::HALF_DIV8;
         ssc_pkg::CKS_DIV64: half_cnt = ssc_pkg::HALF_DIV64;
         default:            half_cnt = ssc_pkg::HALF_DIV2;
      endcase
   end

   assign tick = (mode_b_q.clock_source_select == ssc_pkg::CKS_TIMER3) ?
                 i_timer3_tick : (div_q == half_cnt - 6'h01); // RULE_02

   always_ff @(posedge i_clk) begin
      if (i_reset || state_q == ssc_pkg::ST_IDLE || tick) begin
         div_q <= 6'h00;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // Edge events, from own clock or from the peer clock
   assign m_edge = (state_q != ssc_pkg::ST_IDLE) & tick;
   always_comb begin
      if (mode_b_q.internal_clk) begin
         rise_e = m_edge & ~sck_q; // RULE_01
         fall_e = m_edge & sck_q;
      end else begin
         rise_e = sck_sync_q[1] & ~sck_prev_q;
         fall_e = ~sck_sync_q[1] & sck_prev_q;
      end
   end

   assign tx_edge    = mode_a_q.tx_edge_select ? rise_e : fall_e; // RULE_11
   assign rx_on_rise = ~(mode_a_q.tx_edge_select ^ mode_a_q.rx_edge_select);
   assign rx_edge    = rx_on_rise ? rise_e : fall_e; // RULE_09 RULE_12

   assign master_start = wr & (i_paddr == ssc_pkg::OFS_SHIFT) & mode_b_q.internal_clk &
                         any_en & (state_q == ssc_pkg::ST_IDLE); // RULE_13
   assign slave_start  = (state_q == ssc_pkg::ST_IDLE) & ~mode_b_q.internal_clk & any_en &
                         (rise_e | fall_e);
   assign proc         = (state_q == ssc_pkg::ST_RUN) | slave_start;
   assign last_sample  = proc & rx_edge & ((bit_cnt_q + 4'h1) == len_n);

   always_comb begin
      done = 1'b0;
      if (state_q == ssc_pkg::ST_TAIL) begin
         done = m_edge;
      end else if (last_sample) begin
         done = ~mode_b_q.internal_clk | (~sck_q == idle_lvl);
      end
   end

   // Transfer sequencing
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q <= ssc_pkg::ST_IDLE;
      end else begin
         case (state_q)
            ssc_pkg::ST_IDLE: begin
               if (master_start) begin
                  state_q <= ssc_pkg::ST_RUN; // RULE_06 RULE_13
               end else if (slave_start) begin
                  state_q <= done ? ssc_pkg::ST_IDLE : ssc_pkg::ST_RUN; // RULE_06
               end
            end
            ssc_pkg::ST_RUN: begin
               if (done) begin
                  state_q <= ssc_pkg::ST_IDLE; // RULE_07
               end else if (last_sample) begin
                  state_q <= ssc_pkg::ST_TAIL;
               end
            end
            ssc_pkg::ST_TAIL: begin
               if (done) begin
                  state_q <= ssc_pkg::ST_IDLE; // RULE_07
               end
            end
            default: begin
               state_q <= ssc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Bit counter
   always_ff @(posedge i_clk) begin
      if (i_reset || master_start) begin
         bit_cnt_q <= 4'h0;
      end else if (done) begin
         bit_cnt_q <= 4'h0;
      end else if (proc & rx_edge) begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end
   end

   // Generated shift clock
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sck_q <= 1'b1;
      end else if (state_q == ssc_pkg::ST_IDLE) begin
         sck_q <= idle_lvl;
      end else if (m_edge) begin
         sck_q <= ~sck_q; // RULE_13
      end
   end

   // Transmit path
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tx_sr_q <= ssc_pkg::SHIFT_RST;
         sdo_q   <= 1'b1;
      end else if (wr && i_paddr == ssc_pkg::OFS_SHIFT && state_q == ssc_pkg::ST_IDLE) begin
         tx_sr_q <= i_pwdata[7:0];
      end else if (proc & tx_edge) begin
         if (mode_a_q.lsb_first) begin
            sdo_q   <= tx_sr_q[0]; // RULE_11
            tx_sr_q <= {1'b0, tx_sr_q[7:1]};
         end else begin
            sdo_q   <= tx_sr_q[7]; // RULE_11
            tx_sr_q <= {tx_sr_q[6:0], 1'b0};
         end
      end
   end

   // Receive path
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rx_sr_q <= ssc_pkg::SHIFT_RST;
      end else if (proc & rx_edge) begin
         if (mode_a_q.lsb_first) begin
            rx_sr_q <= {rx_bit, rx_sr_q[7:1]}; // RULE_09
         end else begin
            rx_sr_q <= {rx_sr_q[6:0], rx_bit}; // RULE_09
         end
      end
   end

   // Interrupt status and mask, set wins over clear
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         irq_stat_q <= ssc_pkg::IRQ_RST;
         irq_mask_q <= ssc_pkg::IRQ_RST;
      end else begin
         if (done) begin
            irq_stat_q <= 1'b1; // RULE_07 RULE_13
         end else if (wr && i_paddr == ssc_pkg::OFS_IRQ_STAT &&
                      i_pwdata[ssc_pkg::IRQ_DONE_BIT]) begin
            irq_stat_q <= 1'b0;
         end
         if (wr && i_paddr == ssc_pkg::OFS_IRQ_MASK) begin
            irq_mask_q <= i_pwdata[ssc_pkg::IRQ_DONE_BIT];
         end
      end
   end

   // Pins
   assign o_sck_out = sck_q;
   assign o_sck_oe  = mode_b_q.internal_clk; // RULE_14
   assign o_sdo_out = sdo_q; // RULE_03
   assign o_sdo_oe  = mode_b_q.tx_en; // RULE_05
   assign o_busy    = (state_q != ssc_pkg::ST_IDLE); // RULE_06 RULE_07
   assign o_irq     = irq_stat_q[0] & irq_mask_q[0];

endmodule

// ---- dv/ssc_sync_serial_assertions.sv ----
// Property checker bound to the synchronous serial port
`timescale 1ns/1ps
module ssc_sync_serial_assertions (
   input  wire logic        i_clk,      // Clock
   input  wire logic        i_reset,    // Reset
   input  wire logic        i_psel,     // APB select
   input  wire logic        i_penable,  // APB enable
   input  wire logic        i_pwrite,   // APB write
   input  wire logic [11:0] i_paddr,    // APB address
   input  wire logic [31:0] i_pwdata,   // APB data
   input  wire logic        o_pready,   // APB ready
   input  wire logic        o_pslverr,  // APB error
   input  wire logic        o_sck_out,  // Clock drive
   input  wire logic        o_sck_oe,   // Clock enable
   input  wire logic        o_sdo_out,  // Data drive
   input  wire logic        o_sdo_oe,   // Data enable
   input  wire logic        o_busy,     // Busy
   input  wire logic        o_irq       // Interrupt
);
   logic acc;
   logic wr_b;
   assign acc  = i_psel && i_penable;
   assign wr_b = acc && i_pwrite && i_paddr == ssc_pkg::OFS_MODE_B;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   a_ready_zero_wait: assert property (o_pready == acc)
      else $error("pready differs from access phase");
   a_err_unmapped: assert property (acc |-> o_pslverr == (i_paddr > ssc_pkg::OFS_IRQ_MASK))
      else $error("pslverr wrong for address");
   a_busy_on_start: assert property (
      acc && i_pwrite && i_paddr == ssc_pkg::OFS_SHIFT && !o_busy && o_sck_oe && o_sdo_oe
      |=> o_busy) else $error("buffer write did not start transfer");
   a_done_raises_irq: assert property ($fell(o_busy) |-> o_irq)
      else $error("busy fell without interrupt");
   a_sdo_on_edge: assert property (
      o_sck_oe && o_busy && $changed(o_sdo_out) |-> $changed(o_sck_out))
      else $error("data moved off a clock edge");
   a_mode_drives: assert property (
      wr_b |=> o_sck_oe == $past(i_pwdata[2]) && o_sdo_oe == $past(i_pwdata[4]))
      else $error("line enables do not follow mode");
   a_enables_held: assert property (
      !$past(i_reset) && $changed({o_sck_oe, o_sdo_oe}) |-> $past(wr_b))
      else $error("line enable moved without mode write");
   a_reset_levels: assert property ($fell(i_reset) |->
      o_sck_out && !o_sck_oe && o_sdo_out && !o_sdo_oe && !o_busy && !o_irq)
      else $error("outputs wrong after reset");
   c_done: cover property ($fell(o_busy));
   c_err: cover property (acc && o_pslverr);
   c_slave: cover property ($rose(o_busy) && !o_sck_oe);
endmodule

bind ssc_sync_serial ssc_sync_serial_assertions u_chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .o_sck_out(o_sck_out), .o_sck_oe(o_sck_oe),
   .o_sdo_out(o_sdo_out), .o_sdo_oe(o_sdo_oe), .o_busy(o_busy), .o_irq(o_irq));

// ---- dv/ssc_peer.sv ----
// Serial peer model on the far side of the three lines
`timescale 1ns/1ps
module ssc_peer (
   input  wire logic       i_clk,      // Base clock
   input  wire logic       i_sck,      // Resolved clock line
   input  wire logic       i_sdo,      // Device data out
   input  wire logic       i_tx_edge,  // Device output edge, 1 rising
   output logic            o_sdi,      // Data to device
   output logic            o_sck,      // Clock in slave frames
   output logic            o_sck_oe,   // Peer drives clock
   output logic [7:0]      o_rx        // Bits from device
);
   logic [7:0] tx_q;
   logic       sck_q;
   logic       smp;
   initial begin
      o_sck = 1'b1;
      o_sck_oe = 1'b0;
      sck_q = 1'b1;
   end
   assign smp   = i_tx_edge ? (sck_q && !i_sck) : (!sck_q && i_sck);
   assign o_sdi = tx_q[7];
   always @(posedge i_clk) begin
      sck_q <= i_sck;
      if (smp) begin
         o_rx <= {o_rx[6:0], i_sdo};
         tx_q <= {tx_q[6:0], ~tx_q[7]};
      end
   end
   task automatic load(input logic [7:0] d);
      tx_q <= d;
   endtask
   // Slave frame: idles at the level opposite the output edge, released after
   task automatic frame(input int n, input int half);
      o_sck <= ~i_tx_edge;
      o_sck_oe <= 1'b1;
      repeat (2 * n) begin
         repeat (half) @(posedge i_clk);
         o_sck <= ~o_sck;
      end
      repeat (half) @(posedge i_clk);
      o_sck_oe <= 1'b0;
   endtask
endmodule

// ---- dv/ssc_sync_serial_bench.sv ----
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module ssc_sync_serial_bench;
   logic        clk, rst, psel, pen, pwr, tick, te;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, perr, sck_out, sck_oe, sdo, sdo_oe, busy, irq, sdi, p_sck, p_oe;
   logic [7:0]  p_rx;
   logic [2:0]  tcnt;
   logic        sck_line;
   int          miscompares, n_checks;
   assign sck_line = sck_oe ? sck_out : (p_oe ? p_sck : 1'b1);
   ssc_sync_serial dut (
      .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(perr), .i_timer3_tick(tick), .i_sck_in(sck_line), .o_sck_out(sck_out),
      .o_sck_oe(sck_oe), .i_sdi_in(sdi), .o_sdo_out(sdo), .o_sdo_oe(sdo_oe),
      .o_busy(busy), .o_irq(irq));
   ssc_peer peer (
      .i_clk(clk), .i_sck(sck_line), .i_sdo(sdo), .i_tx_edge(te), .o_sdi(sdi),
      .o_sck(p_sck), .o_sck_oe(p_oe), .o_rx(p_rx));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Timer output pulse every 6 clocks
   always @(posedge clk) begin
      if (rst) begin
         tcnt <= 3'h0;
         tick <= 1'b0;
      end else begin
         tcnt <= (tcnt == 3'h5) ? 3'h0 : tcnt + 3'h1;
         tick <= (tcnt == 3'h5);
      end
   end
   task automatic close_out;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         close_out;
      end
      q = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      // Idle cycle so the next setup never lands in this time step
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(q, exp);
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0) begin
         @(posedge clk);
         n++;
         if (n > 3000) begin
            miscompares++;
            close_out;
         end
      end
   endtask
   task automatic xfer(input logic [7:0] d);
      wr(ssc_pkg::OFS_SHIFT, {24'h0, d});
      @(posedge clk);
      check(busy, 1'b1);
      wait_idle();
      // Peer takes its last bit one clock after busy falls
      @(posedge clk);
   endtask
   task automatic s_regs;
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 5; i++)
         rd(12'(4 * i), 32'h0);
      wr(ssc_pkg::OFS_MODE_A, 32'h0000_00FF);
      rd(ssc_pkg::OFS_MODE_A, 32'h0000_007F);
      wr(ssc_pkg::OFS_MODE_B, 32'h0000_001F);
      rd(ssc_pkg::OFS_MODE_B, 32'h0000_001F);
      apb(1'b0, 12'h014, 32'h0, q, e);
      check(e, 1'b1);
      check(q, 32'h0);
      wr(ssc_pkg::OFS_IRQ_MASK, 32'h1);
      rd(ssc_pkg::OFS_IRQ_MASK, 32'h1);
   endtask
   task automatic s_duplex(input logic e);
      te <= e;
      wr(ssc_pkg::OFS_MODE_A, {26'h0, e, 5'h0});
      wr(ssc_pkg::OFS_MODE_B, 32'h0000_001D);
      @(posedge clk);
      check(sck_out, !e);
      peer.load(8'h3C);
      xfer(8'hA5);
      check(p_rx, 8'hA5);
      rd(ssc_pkg::OFS_SHIFT, 32'h3C);
      rd(ssc_pkg::OFS_IRQ_STAT, 32'h1);
      wr(ssc_pkg::OFS_IRQ_STAT, 32'h1);
      rd(ssc_pkg::OFS_IRQ_STAT, 32'h0);
   endtask
   task automatic s_clk_src;
      logic [5:0] half [4];
      int         n;
      half = '{ssc_pkg::HALF_DIV2, ssc_pkg::HALF_DIV8, ssc_pkg::HALF_DIV64, 6'h06};
      te <= 1'b0;
      wr(ssc_pkg::OFS_MODE_A, 32'h1);
      for (int c = 0; c < 4; c++) begin
         wr(ssc_pkg::OFS_MODE_B, 32'h14 | 32'(c));
         wr(ssc_pkg::OFS_SHIFT, 32'h0);
         n = 0;
         while (sck_out !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
         end
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (sck_out !== 1'b1 && n < 200);
         check(n, half[c]);
         wait_idle();
         wr(ssc_pkg::OFS_IRQ_STAT, 32'h1);
      end
   endtask
   task automatic s_txonly;
      wr(ssc_pkg::OFS_MODE_A, 32'h0);
      wr(ssc_pkg::OFS_MODE_B, 32'h0000_0015);
      peer.load(8'h00);
      xfer(8'h5A);
      check({sdo_oe, p_rx}, 9'h15A);
      rd(ssc_pkg::OFS_SHIFT, 32'hFF);
      wr(ssc_pkg::OFS_IRQ_STAT, 32'h1);
   endtask
   task automatic s_rxslave;
      wr(ssc_pkg::OFS_MODE_B, 32'h0000_0008);
      @(posedge clk);
      check({sck_oe, sdo_oe}, 2'b00);
      peer.load(8'h96);
      peer.frame(8, 8);
      wait_idle();
      rd(ssc_pkg::OFS_SHIFT, 32'h96);
      wr(ssc_pkg::OFS_IRQ_MASK, 32'h0);
      @(posedge clk);
      check(irq, 1'b0);
      wr(ssc_pkg::OFS_IRQ_MASK, 32'h1);
      @(posedge clk);
      check(irq, 1'b1);
      wr(ssc_pkg::OFS_IRQ_STAT, 32'h1);
      @(posedge clk);
      check(irq, 1'b0);
   endtask
   // Master receive only, sampling on the transmit (falling) edge
   task automatic s_same_edge;
      te <= 1'b1;
      wr(ssc_pkg::OFS_MODE_A, 32'h0000_0040);
      wr(ssc_pkg::OFS_MODE_B, 32'h0000_000D);
      peer.load(8'hC3);
      xfer(8'h00);
      rd(ssc_pkg::OFS_SHIFT, 32'hC3);
      rd(ssc_pkg::OFS_MODE_A, 32'h0000_0040);
      rd(ssc_pkg::OFS_IRQ_STAT, 32'h1);
      wr(ssc_pkg::OFS_IRQ_STAT, 32'h1);
   endtask
   initial begin
      rst = 1'b1;
      {psel, pen, pwr, te, paddr, pwdata} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_regs();
      s_duplex(1'b0);
      s_duplex(1'b1);
      s_clk_src();
      s_txonly();
      s_rxslave();
      s_same_edge();
      close_out();
   end
endmodule
